// [core/hpc_top.sv]
// Homing sequencer, protection monitor and coordinate counter with an AHB-Lite register slave.
// Function
// - Mode code 0 two-sensor, 1 three-sensor, 2 push homing; reset value 1.
// - Homing operating speed 1 to 1,000,000 Hz, default 1000.
// - Homing ramp 1 to 1,000,000, default 1000, rate or time units.
// - Homing starting speed 1 to 1,000,000 Hz, default 500.
// - Signed home offset, default 0, adopted only while motion is stopped.
// - Homing starts negative for 0, positive for 1; default 1.
// - Optional slot sensor qualification of home detection, default off.
// - Optional motor phase timing qualification of home detection, default off.
// - Push homing limits current to 0.1 percent units, default 1000.
// - Overload alarm after overload persists programmed 0.1 s units, default 50.
// - Optional alarm when positioning starts without established home, takes effect on execute.
// - Current-off deviation above threshold raises alarm; default 10000.
// - Overload warning after overload persists programmed 0.1 s units, default 50.
// - Overspeed warning above limit in r/min, default 4500, immediate.
// - Deviation above warning threshold raises warning; default 300.
// - Electronic gear numerator and denominator, default 1, applied on execute.
// - Direction sense 0 makes CCW positive, 1 makes CW positive; default 1.
// - Software overtravel detection enabled by setting, default on.
// - Signed soft limits, defaults full 24-bit range, effective immediately.
// - Signed preset position, default 0, loaded on preset request.
// - Wrap enable default off, range default 1000, applied on execute.
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/100ps

module hpc_top
  import hpc_pkg::*;
#(
  parameter int TICK_CYCLES = PROT_TICK_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire hpc_sense_s sense,
  input wire logic cmd_step,
  input wire logic cmd_positive,
  input wire logic motion_busy,
  input wire logic pos_start,
  input wire logic overload,
  input wire logic current_on,
  input wire logic [DEV_W-1:0] deviation,
  input wire logic [RPM_W-1:0] speed_rpm,
  output hpc_move_s move,
  output logic seek_positive,
  output logic homing_busy,
  output logic home_found,
  output logic shaft_step,
  output logic shaft_cw,
  output logic alarm,
  output logic warning,
  output logic stop
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic hreadyout_r, wr_pend_r, rd_pend_r;
  logic [7:0] addr_r;
  logic [31:0] hrdata_r, rdata;
  logic bus_take;

  assign bus_take = hsel && htrans[1] && hready;

  // Reads take one wait state so that a write just before is visible.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hreadyout_r <= 1'b1;
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      hreadyout_r <= !(bus_take && !hwrite);
      wr_pend_r <= bus_take && hwrite;
      rd_pend_r <= bus_take && !hwrite;
      if (bus_take) begin
        addr_r <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
      end
      if (rd_pend_r) begin
        hrdata_r <= rdata;
      end
    end
  end

  assign hreadyout = hreadyout_r;
  assign hrdata = hrdata_r;
  assign hresp = 1'b0;

  function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
    wr_hit = pend && (a == off);
  endfunction

  // ----------------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------------
  logic [CFG_W-1:0] cfg_r;
  logic [SPD_W-1:0] hspeed_r, hramp_r, hstart_r;
  logic signed [POS_W-1:0] hoffset_r, soft_pos_r, soft_neg_r, preset_r, wrap_r;
  logic [CUR_W-1:0] push_cur_r;
  logic [TIM_W-1:0] ovl_alm_r, ovl_wrn_r;
  logic [DEV_W-1:0] dev_alm_r, dev_wrn_r;
  logic [RPM_W-1:0] spd_wrn_r;
  logic [GEAR_W-1:0] gear_a_r, gear_b_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= CFG_RST;
      hspeed_r <= HSPEED_RST;
      hramp_r <= HRAMP_RST;
      hstart_r <= HSTART_RST;
      hoffset_r <= POS_ZERO;
      push_cur_r <= CUR_FULL;
      ovl_alm_r <= OVL_TIME_RST;
      ovl_wrn_r <= OVL_TIME_RST;
      dev_alm_r <= DEV_ALM_RST;
      dev_wrn_r <= DEV_WRN_RST;
      spd_wrn_r <= SPD_WRN_RST;
      gear_a_r <= GEAR_RST;
      gear_b_r <= GEAR_RST;
      soft_pos_r <= SOFT_POS_RST;
      soft_neg_r <= SOFT_NEG_RST;
      preset_r <= POS_ZERO;
      wrap_r <= WRAP_RST;
    end else if (wr_pend_r) begin
      case (addr_r)
        OFF_CFG: cfg_r <= hwdata[CFG_W-1:0];
        OFF_HSPEED: hspeed_r <= hwdata[SPD_W-1:0];
        OFF_HRAMP: hramp_r <= hwdata[SPD_W-1:0];
        OFF_HSTART: hstart_r <= hwdata[SPD_W-1:0];
        OFF_HOFFSET: hoffset_r <= hwdata[POS_W-1:0];
        OFF_PUSHCUR: push_cur_r <= hwdata[CUR_W-1:0];
        OFF_OVL_ALM: ovl_alm_r <= hwdata[TIM_W-1:0];
        OFF_OVL_WRN: ovl_wrn_r <= hwdata[TIM_W-1:0];
        OFF_DEV_ALM: dev_alm_r <= hwdata[DEV_W-1:0];
        OFF_DEV_WRN: dev_wrn_r <= hwdata[DEV_W-1:0];
        OFF_SPD_WRN: spd_wrn_r <= hwdata[RPM_W-1:0];
        OFF_GEAR: begin
          gear_a_r <= hwdata[GEAR_W-1:0];
          gear_b_r <= hwdata[GEAR_B_LO +: GEAR_W];
        end
        OFF_SOFT_POS: soft_pos_r <= hwdata[POS_W-1:0];
        OFF_SOFT_NEG: soft_neg_r <= hwdata[POS_W-1:0];
        OFF_PRESET: preset_r <= hwdata[POS_W-1:0];
        OFF_WRAP: wrap_r <= hwdata[POS_W-1:0];
        default: cfg_r <= cfg_r;
      endcase
    end
  end

  logic home_go, exec_cfg, preset_req, clear_flags;
  logic [1:0] mode;
  assign mode = cfg_r[1:0];
  assign home_go = wr_hit(wr_pend_r, addr_r, OFF_CTRL) && hwdata[CT_HOME];
  assign exec_cfg = wr_hit(wr_pend_r, addr_r, OFF_CTRL) && hwdata[CT_EXEC];
  assign preset_req = wr_hit(wr_pend_r, addr_r, OFF_CTRL) && hwdata[CT_PRESET];
  assign clear_flags = wr_hit(wr_pend_r, addr_r, OFF_CTRL) && hwdata[CT_CLEAR];

  // Settings that only move on an execute command, and the offset that waits for standstill.
  logic unit_act_r, hinc_act_r, wrap_act_r;
  logic [GEAR_W-1:0] gear_a_act_r, gear_b_act_r;
  logic signed [POS_W-1:0] wrap_act_range_r, offset_act_r;
  logic homing_busy_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      unit_act_r <= 1'b0;
      hinc_act_r <= 1'b0;
      wrap_act_r <= 1'b0;
      gear_a_act_r <= GEAR_RST;
      gear_b_act_r <= GEAR_RST;
      wrap_act_range_r <= WRAP_RST;
    end else if (exec_cfg) begin
      unit_act_r <= cfg_r[CB_UNIT];
      hinc_act_r <= cfg_r[CB_HINC];
      wrap_act_r <= cfg_r[CB_WRAP];
      wrap_act_range_r <= wrap_r;
      gear_a_act_r <= gear_a_r;
      gear_b_act_r <= gear_b_r;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      offset_act_r <= POS_ZERO;
    end else if (!motion_busy && !homing_busy_r) begin
      offset_act_r <= hoffset_r;
    end
  end

  // ----------------------------------------------------------------------
  // Homing sequencer
  // ----------------------------------------------------------------------
  hpc_home_e hstate_r;
  logic seek_pos_r, found_r, lim_toward, home_hit;

  assign lim_toward = seek_pos_r ? sense.limit_pos : sense.limit_neg;

  always_comb begin
    case (mode)
      MODE_TWO: home_hit = lim_toward;
      MODE_THREE: home_hit = sense.home;
      MODE_PUSH: home_hit = sense.stall;
      default: home_hit = 1'b0;
    endcase
    if (cfg_r[CB_SLOT] && !sense.slot_sensor_input) begin
      home_hit = 1'b0;
    end
    if (cfg_r[CB_TIM] && !sense.motor_phase_timing_signal) begin
      home_hit = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      hstate_r <= HS_IDLE;
      seek_pos_r <= 1'b1;
      homing_busy_r <= 1'b0;
      found_r <= 1'b0;
    end else begin
      case (hstate_r)
        HS_IDLE: begin
          if (home_go) begin
            hstate_r <= HS_SEEK;
            seek_pos_r <= cfg_r[CB_DIR];
            homing_busy_r <= 1'b1;
            found_r <= 1'b0;
          end
        end
        HS_SEEK: begin
          if (home_hit) begin
            hstate_r <= HS_SET;
          end else if (mode == MODE_THREE && lim_toward) begin
            seek_pos_r <= !seek_pos_r;
          end
        end
        HS_SET: begin
          hstate_r <= HS_IDLE;
          homing_busy_r <= 1'b0;
          found_r <= 1'b1;
        end
        default: hstate_r <= HS_IDLE;
      endcase
    end
  end

  // Speed, ramp and current commands for the profile generator.
  hpc_move_s move_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      move_r <= '0;
    end else begin
      move_r.speed <= hspeed_r;
      move_r.start_speed <= hstart_r;
      move_r.ramp <= hramp_r;
      move_r.ramp_in_seconds <= unit_act_r;
      move_r.current <= (homing_busy_r && mode == MODE_PUSH) ? push_cur_r : CUR_FULL;
    end
  end

  // ----------------------------------------------------------------------
  // Electronic gear and position counter
  // ----------------------------------------------------------------------
  logic [GEAR_W+1:0] acc_r, acc_sum;
  logic step_en, ot_hit, wrap_hi, wrap_lo;
  logic signed [POS_W-1:0] pos_r, pos_nxt, wrap_top;

  assign acc_sum = acc_r + (cmd_step ? {2'b00, gear_b_act_r} : {(GEAR_W + 2){1'b0}});
  assign step_en = acc_sum >= {2'b00, gear_a_act_r};
  assign wrap_top = wrap_act_range_r - POS_ONE;
  assign wrap_hi = wrap_act_r && cmd_positive && pos_r >= wrap_top;
  assign wrap_lo = wrap_act_r && !cmd_positive && pos_r <= POS_ZERO;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      acc_r <= '0;
    end else begin
      acc_r <= step_en ? acc_sum - {2'b00, gear_a_act_r} : acc_sum;
    end
  end

  always_comb begin
    pos_nxt = pos_r;
    ot_hit = 1'b0;
    if (step_en) begin
      if (cfg_r[CB_OT] && (cmd_positive ? pos_r >= soft_pos_r : pos_r <= soft_neg_r)) begin
        ot_hit = 1'b1;
      end else if (wrap_hi) begin
        pos_nxt = POS_ZERO;
      end else if (wrap_lo) begin
        pos_nxt = wrap_top;
      end else begin
        pos_nxt = cmd_positive ? pos_r + POS_ONE : pos_r - POS_ONE;
      end
    end
  end

  logic shaft_step_r, shaft_cw_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pos_r <= POS_ZERO;
      shaft_step_r <= 1'b0;
      shaft_cw_r <= 1'b0;
    end else begin
      if (preset_req) begin
        pos_r <= preset_r;
      end else if (hstate_r == HS_SET) begin
        pos_r <= POS_ZERO - offset_act_r;
      end else begin
        pos_r <= pos_nxt;
      end
      shaft_step_r <= step_en && !ot_hit;
      shaft_cw_r <= cmd_positive ~^ cfg_r[CB_SENSE];
    end
  end

  // ----------------------------------------------------------------------
  // Protection
  // ----------------------------------------------------------------------
  logic [TICK_W-1:0] tick_cnt_r;
  logic tick;
  logic [TIM_W-1:0] ovl_cnt_r;
  logic [2:0] alm_r, wrn_r, alm_set, wrn_set, alm_nxt, wrn_nxt;
  logic lim_r, stop_r, alarm_r, warning_r;

  assign tick = tick_cnt_r == TICK_W'(TICK_CYCLES - 1);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= '0;
      ovl_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + TICK_W'(1);
      if (!overload) begin
        ovl_cnt_r <= '0;
      end else if (tick && ovl_cnt_r != {TIM_W{1'b1}}) begin
        ovl_cnt_r <= ovl_cnt_r + TIM_W'(1);
      end
    end
  end

  always_comb begin
    alm_set = 3'h0;
    wrn_set = 3'h0;
    alm_set[AL_OVL] = overload && ovl_cnt_r >= ovl_alm_r;
    alm_set[AL_DEV] = !current_on && deviation > dev_alm_r;
    alm_set[AL_HINC] = pos_start && hinc_act_r && !found_r;
    wrn_set[WN_OVL] = overload && ovl_cnt_r >= ovl_wrn_r;
    wrn_set[WN_SPD] = speed_rpm > spd_wrn_r;
    wrn_set[WN_DEV] = deviation > dev_wrn_r;
  end

  // Events that arrive with a clear still latch.
  assign alm_nxt = (clear_flags ? 3'h0 : alm_r) | alm_set;
  assign wrn_nxt = (clear_flags ? 3'h0 : wrn_r) | wrn_set;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      alm_r <= 3'h0;
      wrn_r <= 3'h0;
      alarm_r <= 1'b0;
      warning_r <= 1'b0;
      lim_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      alm_r <= alm_nxt;
      wrn_r <= wrn_nxt;
      alarm_r <= |alm_nxt;
      warning_r <= |wrn_nxt;
      lim_r <= (clear_flags ? 1'b0 : lim_r) | ot_hit;
      stop_r <= (|alm_set) || ot_hit || (|alm_r) || (lim_r && !clear_flags);
    end
  end

  // ----------------------------------------------------------------------
  // Read mux and outputs
  // ----------------------------------------------------------------------
  always_comb begin
    rdata = 32'h00000000;
    case (addr_r)
      OFF_CFG: rdata[CFG_W-1:0] = cfg_r;
      OFF_HSPEED: rdata[SPD_W-1:0] = hspeed_r;
      OFF_HRAMP: rdata[SPD_W-1:0] = hramp_r;
      OFF_HSTART: rdata[SPD_W-1:0] = hstart_r;
      OFF_HOFFSET: rdata[POS_W-1:0] = hoffset_r;
      OFF_PUSHCUR: rdata[CUR_W-1:0] = push_cur_r;
      OFF_OVL_ALM: rdata[TIM_W-1:0] = ovl_alm_r;
      OFF_OVL_WRN: rdata[TIM_W-1:0] = ovl_wrn_r;
      OFF_DEV_ALM: rdata[DEV_W-1:0] = dev_alm_r;
      OFF_DEV_WRN: rdata[DEV_W-1:0] = dev_wrn_r;
      OFF_SPD_WRN: rdata[RPM_W-1:0] = spd_wrn_r;
      OFF_GEAR: rdata = {gear_b_r, gear_a_r};
      OFF_SOFT_POS: rdata[POS_W-1:0] = soft_pos_r;
      OFF_SOFT_NEG: rdata[POS_W-1:0] = soft_neg_r;
      OFF_PRESET: rdata[POS_W-1:0] = preset_r;
      OFF_WRAP: rdata[POS_W-1:0] = wrap_r;
      OFF_STATUS: rdata[8:0] = {found_r, homing_busy_r, lim_r, wrn_r, alm_r};
      OFF_POS: rdata[POS_W-1:0] = pos_r;
      default: rdata = 32'h00000000;
    endcase
  end

  assign move = move_r;
  assign seek_positive = seek_pos_r;
  assign homing_busy = homing_busy_r;
  assign home_found = found_r;
  assign shaft_step = shaft_step_r;
  assign shaft_cw = shaft_cw_r;
  assign alarm = alarm_r;
  assign warning = warning_r;
  assign stop = stop_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  a_push_current: assert property (
    (homing_busy_r && mode == MODE_PUSH) |=> move_r.current == $past(push_cur_r))
    else $error("push current not applied");
  a_start_dir: assert property (
    (hstate_r == HS_IDLE && home_go) |=> seek_pos_r == $past(cfg_r[CB_DIR]) && homing_busy_r)
    else $error("homing start direction wrong");
  a_home_offset: assert property (
    (hstate_r == HS_SET && !preset_req) |=> pos_r == POS_ZERO - $past(offset_act_r) && found_r)
    else $error("home offset not loaded");
  a_ovl_alarm: assert property (
    (overload && ovl_cnt_r >= ovl_alm_r) |=> alm_r[AL_OVL] && alarm)
    else $error("overload alarm missing");
  a_speed_warn: assert property (
    speed_rpm > spd_wrn_r |=> wrn_r[WN_SPD])
    else $error("overspeed warning missing");
  a_dev_alarm: assert property (
    (!current_on && deviation > dev_alm_r) |=> alm_r[AL_DEV] ##1 stop_r)
    else $error("deviation alarm missing");
  a_home_incomplete: assert property (
    (pos_start && hinc_act_r && !found_r) |=> alm_r[AL_HINC])
    else $error("home incomplete alarm missing");
  a_ot_block: assert property (
    (ot_hit && !preset_req && hstate_r != HS_SET) |=> $stable(pos_r) && lim_r && !shaft_step_r)
    else $error("overtravel step not blocked");
  a_wrap_fold: assert property (
    (step_en && !ot_hit && wrap_hi && !preset_req && hstate_r != HS_SET) |=> pos_r == POS_ZERO)
    else $error("wrap fold failed");
  a_preset_load: assert property (
    preset_req |=> pos_r == $past(preset_r))
    else $error("preset not loaded");

  c_homing_done: cover property (home_go ##[1:1000] found_r);
  c_ot_event: cover property (ot_hit);
  c_wrap_roll: cover property (step_en && wrap_lo);

endmodule

// [core/hpc_pkg.sv]
// Constants, types and register map for the homing, protection and coordinate block.
package hpc_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int PROT_UNIT_MS = 100;
  localparam int PROT_TICK_CYC = CLK_HZ / 1000 * PROT_UNIT_MS;

  // ----------------------------------------------------------------------
  // Field widths
  // ----------------------------------------------------------------------
  localparam int SPD_W = 20;
  localparam int POS_W = 24;
  localparam int CUR_W = 10;
  localparam int TIM_W = 9;
  localparam int DEV_W = 16;
  localparam int RPM_W = 13;
  localparam int GEAR_W = 16;
  localparam int CFG_W = 10;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CFG = 8'h00;
  localparam logic [7:0] OFF_HSPEED = 8'h04;
  localparam logic [7:0] OFF_HRAMP = 8'h08;
  localparam logic [7:0] OFF_HSTART = 8'h0C;
  localparam logic [7:0] OFF_HOFFSET = 8'h10;
  localparam logic [7:0] OFF_PUSHCUR = 8'h14;
  localparam logic [7:0] OFF_OVL_ALM = 8'h18;
  localparam logic [7:0] OFF_OVL_WRN = 8'h1C;
  localparam logic [7:0] OFF_DEV_ALM = 8'h20;
  localparam logic [7:0] OFF_DEV_WRN = 8'h24;
  localparam logic [7:0] OFF_SPD_WRN = 8'h28;
  localparam logic [7:0] OFF_GEAR = 8'h2C;
  localparam logic [7:0] OFF_SOFT_POS = 8'h30;
  localparam logic [7:0] OFF_SOFT_NEG = 8'h34;
  localparam logic [7:0] OFF_PRESET = 8'h38;
  localparam logic [7:0] OFF_WRAP = 8'h3C;
  localparam logic [7:0] OFF_CTRL = 8'h40;
  localparam logic [7:0] OFF_STATUS = 8'h44;
  localparam logic [7:0] OFF_POS = 8'h48;

  // ----------------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------------
  localparam int CB_DIR = 2;
  localparam int CB_SLOT = 3;
  localparam int CB_TIM = 4;
  localparam int CB_UNIT = 5;
  localparam int CB_HINC = 6;
  localparam int CB_SENSE = 7;
  localparam int CB_OT = 8;
  localparam int CB_WRAP = 9;
  localparam int GEAR_B_LO = 16;
  localparam int CT_HOME = 0;
  localparam int CT_EXEC = 1;
  localparam int CT_PRESET = 2;
  localparam int CT_CLEAR = 3;
  localparam int AL_OVL = 0;
  localparam int AL_DEV = 1;
  localparam int AL_HINC = 2;
  localparam int WN_OVL = 0;
  localparam int WN_SPD = 1;
  localparam int WN_DEV = 2;
  localparam logic [1:0] MODE_TWO = 2'h0;
  localparam logic [1:0] MODE_THREE = 2'h1;
  localparam logic [1:0] MODE_PUSH = 2'h2;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RST = 10'h185;
  localparam logic [SPD_W-1:0] HSPEED_RST = 20'h003E8;
  localparam logic [SPD_W-1:0] HRAMP_RST = 20'h003E8;
  localparam logic [SPD_W-1:0] HSTART_RST = 20'h001F4;
  localparam logic [CUR_W-1:0] CUR_FULL = 10'h3E8;
  localparam logic [TIM_W-1:0] OVL_TIME_RST = 9'h032;
  localparam logic [DEV_W-1:0] DEV_ALM_RST = 16'h2710;
  localparam logic [DEV_W-1:0] DEV_WRN_RST = 16'h012C;
  localparam logic [RPM_W-1:0] SPD_WRN_RST = 13'h1194;
  localparam logic [GEAR_W-1:0] GEAR_RST = 16'h0001;
  localparam logic signed [POS_W-1:0] SOFT_POS_RST = 24'sh7FFFFF;
  localparam logic signed [POS_W-1:0] SOFT_NEG_RST = 24'sh800000;
  localparam logic signed [POS_W-1:0] POS_ZERO = 24'sh000000;
  localparam logic signed [POS_W-1:0] POS_ONE = 24'sh000001;
  localparam logic signed [POS_W-1:0] WRAP_RST = 24'sh0003E8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {HS_IDLE, HS_SEEK, HS_SET} hpc_home_e;

  typedef struct packed {
    logic [SPD_W-1:0] speed;
    logic [SPD_W-1:0] start_speed;
    logic [SPD_W-1:0] ramp;
    logic ramp_in_seconds;
    logic [CUR_W-1:0] current;
  } hpc_move_s;

  typedef struct packed {
    logic home;
    logic limit_pos;
    logic limit_neg;
    logic slot_sensor_input;
    logic motor_phase_timing_signal;
    logic stall;
  } hpc_sense_s;

endpackage

// [verification/hpc_mech_model.sv]
// Motor shaft and home sensor model that follows the applied steps.
`timescale 1ns/100ps
module hpc_mech_model
  import hpc_pkg::*;
#(
  parameter int HOME_AT = 4
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic shaft_step,
  input wire logic shaft_cw,
  output hpc_sense_s sense
);
  logic signed [POS_W-1:0] pos_r;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) pos_r <= POS_ZERO;
    else if (shaft_step) pos_r <= shaft_cw ? pos_r + POS_ONE : pos_r - POS_ONE;
  end
  // The home sensor is lit only while the shaft sits on the home mark.
  // A hard stop at the same mark makes the shaft stall there.
  assign sense = {pos_r == HOME_AT, 4'h0, pos_r == HOME_AT};
endmodule

// [verification/hpc_top_bench.sv]
// Self-checking bench for the homing, protection and coordinate block.
`timescale 1ns/100ps
module hpc_top_bench
  import hpc_pkg::*;
;
  logic clock, rstn, hsel, hwrite, hready, cmd_step, cmd_positive, motion_busy, pos_start;
  logic overload, current_on, hreadyout, hresp, seek_positive, homing_busy, home_found;
  logic shaft_step, shaft_cw, alarm, warning, stop;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans;
  logic [DEV_W-1:0] deviation;
  logic [RPM_W-1:0] speed_rpm;
  hpc_sense_s sense;
  hpc_move_s move;
  int failures, comparisons, cycles, steps, s;
  localparam logic [7:0] ADR [15] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h14, 8'h18, 8'h1C,
    8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h3C, 8'h4C};
  localparam logic [31:0] EXP [15] = '{32'h185, 32'h3E8, 32'h3E8, 32'h1F4, 32'h3E8, 32'h32,
    32'h32, 32'h2710, 32'h12C, 32'h1194, 32'h10001, 32'h7FFFFF, 32'h800000, 32'h3E8, 32'h0};
  assign hready = hreadyout;
  hpc_top #(.TICK_CYCLES(10)) i_dut (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sense(sense), .cmd_step(cmd_step),
    .cmd_positive(cmd_positive), .motion_busy(motion_busy), .pos_start(pos_start),
    .overload(overload), .current_on(current_on), .deviation(deviation), .speed_rpm(speed_rpm),
    .move(move), .seek_positive(seek_positive), .homing_busy(homing_busy),
    .home_found(home_found), .shaft_step(shaft_step), .shaft_cw(shaft_cw), .alarm(alarm),
    .warning(warning), .stop(stop));
  hpc_mech_model i_model (.clock(clock), .rstn(rstn), .shaft_step(shaft_step),
    .shaft_cw(shaft_cw), .sense(sense));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles = cycles + 1;
    steps = steps + shaft_step;
    if (cycles == 20000) begin
      failures = failures + 1;
      end_sim();
    end
  end
  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task end_sim;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    rdat = hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task step(input logic dir, input int n);
    for (int i = 0; i < n; i++) begin
      cmd_step <= 1'b1;
      cmd_positive <= dir;
      @(posedge clock);
      cmd_step <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  task t_move;
    for (int i = 0; i < 15; i++) begin
      rchk(ADR[i], EXP[i]);
    end
    chk(move.speed, HSPEED_RST);
    chk(move.ramp, HRAMP_RST);
    chk(move.start_speed, HSTART_RST);
    chk({move.ramp_in_seconds, move.current}, {1'b0, CUR_FULL});
  endtask
  task t_home;
    bus(1'b1, OFF_CFG, 32'h1C5);
    bus(1'b1, OFF_CTRL, 32'h2);
    pos_start <= 1'b1;
    @(posedge clock);
    pos_start <= 1'b0;
    repeat (2) @(posedge clock);
    chk(alarm, 1'b1);
    bus(1'b1, OFF_CFG, 32'h185);
    bus(1'b1, OFF_CTRL, 32'hA);
    bus(1'b1, OFF_HOFFSET, 32'hFFFFFFFD);
    bus(1'b1, OFF_CTRL, 32'h1);
    repeat (12) if (home_found !== 1'b1) step(1'b1, 1);
    chk(home_found, 1'b1);
    rchk(OFF_POS, 32'h3);
    bus(1'b1, OFF_PUSHCUR, 32'h64);
    bus(1'b1, OFF_CFG, 32'h186);
    bus(1'b1, OFF_CTRL, 32'h1);
    repeat (2) @(posedge clock);
    chk(move.current, 32'h64);
    bus(1'b1, OFF_CFG, 32'h101);
    step(1'b1, 1);
    chk(shaft_cw, 1'b0);
    bus(1'b1, OFF_CTRL, 32'h1);
    @(posedge clock);
    chk(seek_positive, 1'b0);
    step(1'b0, 1);
    chk(home_found, 1'b1);
    bus(1'b1, OFF_CFG, 32'h185);
  endtask
  task t_limit;
    bus(1'b1, OFF_PRESET, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h4);
    rchk(OFF_POS, 32'h0);
    bus(1'b1, OFF_SOFT_POS, 32'h2);
    s = steps;
    step(1'b1, 3);
    chk(steps - s, 32'h2);
    chk(stop, 1'b1);
    bus(1'b1, OFF_SOFT_POS, 32'h7FFFFF);
    bus(1'b1, OFF_GEAR, 32'h10002);
    bus(1'b1, OFF_CTRL, 32'hA);
    s = steps;
    step(1'b1, 4);
    chk(steps - s, 32'h2);
    bus(1'b1, OFF_GEAR, 32'h10001);
    bus(1'b1, OFF_WRAP, 32'h3);
    bus(1'b1, OFF_CFG, 32'h385);
    bus(1'b1, OFF_CTRL, 32'h6);
    step(1'b0, 1);
    rchk(OFF_POS, 32'h2);
    step(1'b1, 2);
    rchk(OFF_POS, 32'h1);
  endtask
  task t_prot;
    bus(1'b1, OFF_OVL_ALM, 32'h3);
    bus(1'b1, OFF_OVL_WRN, 32'h6);
    overload <= 1'b1;
    repeat (18) @(posedge clock);
    chk(alarm, 1'b0);
    repeat (27) @(posedge clock);
    chk({alarm, warning}, 2'h2);
    repeat (40) @(posedge clock);
    chk(warning, 1'b1);
    overload <= 1'b0;
    bus(1'b1, OFF_DEV_ALM, 32'h5);
    bus(1'b1, OFF_SPD_WRN, 32'h64);
    bus(1'b1, OFF_CTRL, 32'h8);
    deviation <= 16'h0005;
    speed_rpm <= 13'h0064;
    repeat (3) @(posedge clock);
    chk({alarm, warning}, 2'h0);
    deviation <= 16'h0006;
    speed_rpm <= 13'h0065;
    repeat (3) @(posedge clock);
    chk({alarm, warning}, 2'h3);
  endtask
  initial begin
    {rstn, hsel, hwrite, cmd_step, cmd_positive, motion_busy, pos_start} = 7'h00;
    {overload, current_on, haddr, hwdata, htrans} = 68'h0;
    deviation = 16'h0000;
    speed_rpm = 13'h0000;
    {failures, comparisons, cycles, steps} = 128'h0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_move();
    t_home();
    t_limit();
    t_prot();
    end_sim();
  end
endmodule
